// [logic/etcc_pkg.sv]
// elapsed time capture counter: shared constants for both link ends
// assumes a single 25 MHz reference clock shared by device and host logic
package etcc_pkg;

    // ------------------------------------------------------------
    // device register map (serial addresses, 7 bits)
    // ------------------------------------------------------------
    localparam logic [6:0] REG_CTRL = 7'h00;
    localparam logic [6:0] REG_PIN0 = 7'h02;
    localparam logic [6:0] REG_CAP0 = 7'h10;
    localparam logic [6:0] REG_CAP_MSB = 7'h14;
    localparam int CAP_BYTES = 5;
    localparam int COUNT_W = 40;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_VCO_BIT = 2;
    localparam int CTRL_CLR_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // pin configuration fields
    localparam logic [6:0] PIN_FUNC_CAPTURE = 7'h27;
    localparam int PIN_POL_BIT = 7;
    localparam logic [7:0] PIN_RESET = 8'h00;

    // counter clock prescale ratios
    localparam logic [4:0] DIV_THIRD = 5'h08;
    localparam logic [4:0] DIV_SECOND = 5'h14;

    // serial command byte
    localparam int CMD_RD_BIT = 7;

    // ------------------------------------------------------------
    // host register map and timing
    // ------------------------------------------------------------
    localparam logic [3:0] HREG_CMD = 4'h0;
    localparam logic [3:0] HREG_LEN = 4'h1;
    localparam logic [3:0] HREG_CTRL = 4'h2;
    localparam logic [3:0] HREG_TRIG = 4'h3;
    localparam logic [3:0] HREG_BUF0 = 4'h4;
    localparam logic [2:0] MAX_LEN = 3'h5;

    localparam int CLK_NS = 40;
    localparam int GUARD_NS = 1000;
    localparam int HOLD_NS = 10;
    localparam logic [7:0] GUARD_CYC = 8'((GUARD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam int SCLK_HALF = 8;

endpackage

// [logic/etcc_if.sv]
// elapsed time capture counter: serial link and trigger pins between host and device
// assumes both ends run on their own copy of the same reference clock
`timescale 1ns/1ps

interface etcc_if #(
    parameter int N_PINS = 2
) ();
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic [N_PINS-1:0] trig;

    modport device (
        input sclk,
        input cs_n,
        input mosi,
        input trig,
        output miso
    );

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        output trig,
        input miso
    );
endinterface

// [logic/etcc_device.sv]
// elapsed time capture counter: device end with serial register port
// assumes vco tick inputs are one-cycle pulses from logic on ref_clk
// link pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps

// How it works
// - 40-bit count copied on accepted trigger
// - triggers: pin edge or chip-select fall
// - rearm only after low byte read
// - count clock is vco/8 or vco/20
// - vco select 0 third, 1 second
// - source select 1 pin, 0 chip-select
// - disabled counter held at zero
// - each chip-select fall captures while enabled, armed and source select 0
// - high byte read blocks chip-select captures
// - capture and rearm within one burst
// - pin code 0x27 captures, polarity selectable
// - pin capture locks until low byte
// - host keeps trigger off near enable
// - host waits 1 us after rearm
// - counter wraps from all ones to zero
// - software handles wrap, resets by enable
// - vco select also drives validation clock
// - software divides difference by clock rate
// - capture exposed as five byte registers
// - clear bit zero for normal counting
// - absolute measurement from enable rising
module etcc_device #(
    parameter int N_PINS = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // link to host
    etcc_if.device link,
    // vco tick pulses
    input wire logic third_loop_pll_tick,
    input wire logic second_loop_pll_tick,
    // to reference validation
    output logic validation_vco_select
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (N_PINS < 1 || N_PINS > 8) begin : g_bad_pins
        $error("etcc_device: N_PINS must be 1 to 8");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ETCC_IDLE = 3'h1,
        ETCC_CMD = 3'h2,
        ETCC_DATA = 3'h4
    } etcc_ser_e;

    typedef struct packed {
        etcc_ser_e st;
        logic [2:0] cs_sy;
        logic [2:0] sck_sy;
        logic [1:0] mosi_sy;
        logic [N_PINS-1:0] pin_s1;
        logic [N_PINS-1:0] pin_s2;
        logic [N_PINS-1:0] pin_d;
        logic [2:0] bit_cnt;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [6:0] addr;
        logic rd;
        logic miso;
        logic [7:0] ctrl;
        logic [N_PINS-1:0][7:0] pcfg;
        logic [4:0] presc;
        logic [etcc_pkg::COUNT_W-1:0] cnt;
        logic [etcc_pkg::COUNT_W-1:0] cap;
        logic armed;
        logic vsel;
    } etcc_dev_s;

    etcc_dev_s r;
    etcc_dev_s next_r;

    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_low;
    logic [7:0] byte_in;
    logic wr_en;
    logic lsb_read;
    logic msb_read;
    logic run;
    logic tick;
    logic [4:0] div_last;
    logic [N_PINS-1:0] pin_edge;
    logic trig_hit;
    logic cap_hit;

    // register read mux; the capture bytes sit low byte first
    function automatic logic [7:0] read_reg(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == etcc_pkg::REG_CTRL) begin
            v = r.ctrl;
        end
        for (int i = 0; i < N_PINS; i++) begin
            if (a == etcc_pkg::REG_PIN0 + 7'(i)) begin
                v = r.pcfg[i];
            end
        end
        for (int i = 0; i < etcc_pkg::CAP_BYTES; i++) begin
            if (a == etcc_pkg::REG_CAP0 + 7'(i)) begin
                v = r.cap[8*i +: 8];
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        wr_en = 1'b0;
        lsb_read = 1'b0;
        msb_read = 1'b0;

        // two-flop synchronisers, edges from second stage on
        next_r.cs_sy = {r.cs_sy[1:0], link.cs_n};
        next_r.sck_sy = {r.sck_sy[1:0], link.sclk};
        next_r.mosi_sy = {r.mosi_sy[0], link.mosi};
        next_r.pin_s1 = link.trig;
        next_r.pin_s2 = r.pin_s1;
        next_r.pin_d = r.pin_s2;

        sck_rise = r.sck_sy[1] & ~r.sck_sy[2];
        sck_fall = ~r.sck_sy[1] & r.sck_sy[2];
        cs_fall = ~r.cs_sy[1] & r.cs_sy[2];
        cs_low = ~r.cs_sy[1];
        byte_in = {r.rx[6:0], r.mosi_sy[1]};

        // serial frame: command byte, then auto-incrementing data bytes
        case (r.st)
            ETCC_IDLE: begin
                if (cs_fall) begin
                    next_r.st = ETCC_CMD;
                    next_r.bit_cnt = 3'h0;
                end
            end
            ETCC_CMD, ETCC_DATA: begin
                if (!cs_low) begin
                    next_r.st = ETCC_IDLE;
                end else if (sck_rise) begin
                    next_r.rx = byte_in;
                    next_r.bit_cnt = r.bit_cnt + 3'h1;
                    if (r.bit_cnt == 3'h7) begin
                        if (r.st == ETCC_CMD) begin
                            next_r.st = ETCC_DATA;
                            next_r.rd = byte_in[etcc_pkg::CMD_RD_BIT];
                            next_r.addr = byte_in[6:0];
                            next_r.tx = read_reg(byte_in[6:0]);
                        end else begin
                            // read side effects fire only once a byte is fully shifted out,
                            // so a burst that stops early never locks or rearms by accident
                            if (r.rd) begin
                                // rearm and lock in one burst
                                lsb_read = (r.addr == etcc_pkg::REG_CAP0);
                                msb_read = (r.addr == etcc_pkg::REG_CAP_MSB);
                            end else begin
                                wr_en = 1'b1;
                            end
                            next_r.addr = r.addr + 7'h01;
                            next_r.tx = read_reg(r.addr + 7'h01);
                        end
                    end
                end else if (sck_fall) begin
                    next_r.miso = r.tx[7];
                    next_r.tx = {r.tx[6:0], 1'b0};
                end
            end
            default: begin
                next_r.st = ETCC_IDLE;
            end
        endcase

        if (wr_en) begin
            if (r.addr == etcc_pkg::REG_CTRL) begin
                next_r.ctrl = byte_in;
            end
            for (int i = 0; i < N_PINS; i++) begin
                if (r.addr == etcc_pkg::REG_PIN0 + 7'(i)) begin
                    next_r.pcfg[i] = byte_in;
                end
            end
        end

        tick = r.ctrl[etcc_pkg::CTRL_VCO_BIT] ? second_loop_pll_tick : third_loop_pll_tick;
        div_last = r.ctrl[etcc_pkg::CTRL_VCO_BIT] ? etcc_pkg::DIV_SECOND - 5'h01 : etcc_pkg::DIV_THIRD - 5'h01;
        run = r.ctrl[etcc_pkg::CTRL_EN_BIT] & ~r.ctrl[etcc_pkg::CTRL_CLR_BIT];

        if (!run) begin
            next_r.cnt = '0;
            next_r.presc = 5'h00;
        end else if (tick) begin
            if (r.presc >= div_last) begin
                next_r.presc = 5'h00;
                next_r.cnt = r.cnt + 40'h00_0000_0001;
            end else begin
                next_r.presc = r.presc + 5'h01;
            end
        end

        for (int i = 0; i < N_PINS; i++) begin
            pin_edge[i] = (r.pcfg[i][6:0] == etcc_pkg::PIN_FUNC_CAPTURE)
                & (r.pin_s2[i] ^ r.pcfg[i][etcc_pkg::PIN_POL_BIT])
                & ~(r.pin_d[i] ^ r.pcfg[i][etcc_pkg::PIN_POL_BIT]);
        end

        trig_hit = r.ctrl[etcc_pkg::CTRL_SRC_BIT] ? |pin_edge : cs_fall;
        cap_hit = r.ctrl[etcc_pkg::CTRL_EN_BIT] & r.armed & trig_hit;

        if (cap_hit) begin
            next_r.cap = r.cnt;
        end

        // locking beats rearming when both land in one cycle
        // pin capture locks
        if ((cap_hit & r.ctrl[etcc_pkg::CTRL_SRC_BIT]) | msb_read) begin
            next_r.armed = 1'b0;
        end else if (lsb_read) begin
            next_r.armed = 1'b1;
        end

        next_r.vsel = r.ctrl[etcc_pkg::CTRL_VCO_BIT];
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.st <= ETCC_IDLE;
            r.cs_sy <= 3'h7;
            r.ctrl <= etcc_pkg::CTRL_RESET;
            r.pcfg <= {N_PINS{etcc_pkg::PIN_RESET}};
            r.armed <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.miso = r.miso;
    assign validation_vco_select = r.vsel;

endmodule // etcc_device

// [logic/etcc_host.sv]
// elapsed time capture counter: host end driving the serial link and trigger pins
// assumes software reaches it over a plain one-cycle strobe port on ref_clk
`timescale 1ns/1ps

module etcc_host #(
    parameter int N_PINS = 2,
    parameter int HALF = etcc_pkg::SCLK_HALF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // software port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // link to device
    etcc_if.host link
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // miso crosses two flops plus the device's own latency, so a half period below 6 misreads
    if (HALF < 8 || HALF > 255 || N_PINS < 1 || N_PINS > 8) begin : g_bad_param
        $error("etcc_host: HALF must be 8 to 255, N_PINS 1 to 8");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ETCC_H_IDLE = 3'h1,
        ETCC_H_SHIFT = 3'h2,
        ETCC_H_END = 3'h4
    } etcc_hst_e;

    typedef struct packed {
        etcc_hst_e st;
        logic [7:0] div;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] cmd;
        logic [2:0] len;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [4:0][7:0] buf_b;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [1:0] miso_sy;
        logic [N_PINS-1:0] trig_req;
        logic [N_PINS-1:0] trig;
        logic [7:0] guard;
        logic [7:0] hold;
        logic [7:0] rdata;
    } etcc_hst_s;

    etcc_hst_s r;
    etcc_hst_s next_r;
    logic [7:0] nxt;

    always_comb begin
        next_r = r;
        nxt = 8'h00;
        next_r.miso_sy = {r.miso_sy[0], link.miso};
        next_r.rdata = 8'h00;

        // software port
        if (wr) begin
            case (addr)
                etcc_pkg::HREG_CMD: next_r.cmd = wdata;
                etcc_pkg::HREG_LEN: next_r.len = (wdata[2:0] > etcc_pkg::MAX_LEN) ? etcc_pkg::MAX_LEN : wdata[2:0];
                etcc_pkg::HREG_TRIG: next_r.trig_req = wdata[N_PINS-1:0];
                default: begin
                end
            endcase
            for (int i = 0; i < 5; i++) begin
                if (addr == etcc_pkg::HREG_BUF0 + 4'(i)) begin
                    next_r.buf_b[i] = wdata;
                end
            end
        end
        if (rd) begin
            case (addr)
                etcc_pkg::HREG_CMD: next_r.rdata = r.cmd;
                etcc_pkg::HREG_LEN: next_r.rdata = {5'h00, r.len};
                etcc_pkg::HREG_CTRL: next_r.rdata = {7'h00, r.st != ETCC_H_IDLE};
                etcc_pkg::HREG_TRIG: next_r.rdata = 8'(r.trig);
                default: begin
                end
            endcase
            for (int i = 0; i < 5; i++) begin
                if (addr == etcc_pkg::HREG_BUF0 + 4'(i)) begin
                    next_r.rdata = r.buf_b[i];
                end
            end
        end

        // serial frame engine, mode 0: device samples on rise
        case (r.st)
            ETCC_H_IDLE: begin
                if (wr && addr == etcc_pkg::HREG_CTRL && wdata[0]) begin
                    next_r.st = ETCC_H_SHIFT;
                    next_r.cs_n = 1'b0;
                    next_r.mosi = r.cmd[7];
                    next_r.tx = {r.cmd[6:0], 1'b0};
                    next_r.div = 8'h00;
                    next_r.bit_cnt = 3'h0;
                    next_r.byte_cnt = 3'h0;
                end
            end
            ETCC_H_SHIFT: begin
                if (r.div == HALF_LAST) begin
                    next_r.div = 8'h00;
                    if (!r.sclk) begin
                        next_r.sclk = 1'b1;
                        next_r.rx = {r.rx[6:0], r.miso_sy[1]};
                    end else begin
                        next_r.sclk = 1'b0;
                        next_r.bit_cnt = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == 3'h7) begin
                            if (r.cmd[7] && r.byte_cnt != 3'h0) begin
                                next_r.buf_b[r.byte_cnt - 3'h1] = r.rx;
                            end
                            next_r.byte_cnt = r.byte_cnt + 3'h1;
                            if (r.byte_cnt == r.len) begin
                                next_r.st = ETCC_H_END;
                            end else begin
                                nxt = r.cmd[7] ? 8'h00 : r.buf_b[r.byte_cnt];
                                next_r.mosi = nxt[7];
                                next_r.tx = {nxt[6:0], 1'b0};
                            end
                        end else begin
                            next_r.mosi = r.tx[7];
                            next_r.tx = {r.tx[6:0], 1'b0};
                        end
                    end
                end else begin
                    next_r.div = r.div + 8'h01;
                end
            end
            ETCC_H_END: begin
                if (r.div == HALF_LAST) begin
                    next_r.st = ETCC_H_IDLE;
                    next_r.cs_n = 1'b1;
                    next_r.mosi = 1'b0;
                    next_r.guard = etcc_pkg::GUARD_CYC;
                end else begin
                    next_r.div = r.div + 8'h01;
                end
            end
            default: begin
                next_r.st = ETCC_H_IDLE;
            end
        endcase

        // trigger pins change only outside the guard window and after the hold time
        if (r.guard != 8'h00) begin
            next_r.guard = r.guard - 8'h01;
        end
        if (r.hold != 8'h00) begin
            next_r.hold = r.hold - 8'h01;
        end
        // hold trigger level
        // never on the edge that opens a frame, so trig stays still while cs_n is low
        if (r.guard == 8'h00 && r.hold == 8'h00 && r.trig != r.trig_req && r.st == ETCC_H_IDLE
            && next_r.st == ETCC_H_IDLE) begin
            next_r.trig = r.trig_req;
            next_r.hold = etcc_pkg::HOLD_CYC;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.st <= ETCC_H_IDLE;
            r.cs_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.sclk = r.sclk;
    assign link.cs_n = r.cs_n;
    assign link.mosi = r.mosi;
    assign link.trig = r.trig;
    assign rdata = r.rdata;

endmodule // etcc_host

// [testbench/etcc_checker.sv]
// elapsed time capture counter: checker on the serial link and trigger pins
// assumes both ends share ref_clk and the host keeps its default sclk half period of 8
`timescale 1ns/1ps

module etcc_checker #(
    parameter int N_PINS = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic [N_PINS-1:0] trig
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // frame helpers
    // ----------------------------------------
    // idle_cyc saturates so a long idle spell never wraps back into the guard window
    logic [7:0] idle_cyc;
    logic [9:0] rise_cnt;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_cyc <= 8'hff;
            rise_cnt <= 10'h000;
        end else begin
            idle_cyc <= cs_n ? idle_cyc + {7'h00, idle_cyc != 8'hff} : 8'h00;
            rise_cnt <= cs_n ? 10'h000 : rise_cnt + {9'h000, $rose(sclk)};
        end
    end

    // ----------------------------------------
    // link rules
    // ----------------------------------------
    a_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("sclk moved outside a frame");
    a_first_edge_gap: assert property ($fell(cs_n) |-> (!sclk)[*4] ##[4:5] sclk)
        else $error("first sclk rise misplaced");
    a_high_phase: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("sclk high phase not 8 cycles");
    a_low_phase: assert property ($fell(sclk) |-> (!sclk)[*8])
        else $error("sclk low phase too short");
    a_mosi_steady: assert property (!cs_n && sclk |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    a_whole_bytes: assert property ($rose(cs_n) |-> rise_cnt != 10'h000 && rise_cnt[2:0] == 3'h0)
        else $error("frame ended on a partial byte");
    a_frame_bounded: assert property ($fell(cs_n) |-> ##[100:1000] $rose(cs_n))
        else $error("frame length out of range");
    a_trig_in_frame: assert property (!cs_n |-> $stable(trig))
        else $error("trigger moved inside a frame");
    a_trig_guard: assert property (!$stable(trig) |-> idle_cyc >= etcc_pkg::GUARD_CYC - 8'h01)
        else $error("trigger moved too soon after a frame");

    c_frame: cover property ($fell(cs_n) ##[100:1000] $rose(cs_n));
    c_trig_move: cover property (!$stable(trig));
    c_full_capture: cover property ($rose(cs_n) && rise_cnt == 10'h030);
endmodule // etcc_checker

// [testbench/elapsed_time_capture_counter_bench.sv]
// elapsed time capture counter: bench joining host and device across the link
// assumes package, link interface, both ends and the checker are compiled first
`timescale 1ns/1ps

module elapsed_time_capture_counter_bench;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic third_loop_pll_tick = 1'b0;
    logic second_loop_pll_tick = 1'b0;
    logic validation_vco_select;
    logic vco = 1'b0;
    logic stamp_lvl = 1'b1;
    logic [7:0] b8;
    logic [39:0] rx;
    logic [39:0] c1;
    longint thr_cnt = 0;
    longint sec_cnt = 0;
    longint cs_stamp = 0;
    longint pin_stamp = 0;
    longint s1;
    int seed = 50;
    int rnd;
    int err_total = 0;
    int samples_checked = 0;

    etcc_if #(.N_PINS(2)) link ();
    etcc_host #(.N_PINS(2)) etcc_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
    etcc_device #(.N_PINS(2)) etcc_device_i (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
        .third_loop_pll_tick(third_loop_pll_tick), .second_loop_pll_tick(second_loop_pll_tick),
        .validation_vco_select(validation_vco_select));
    etcc_checker #(.N_PINS(2)) etcc_checker_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .trig(link.trig));

    always #20 ref_clk = ~ref_clk;

    // the model counts exactly the random ticks it hands over
    always @(posedge ref_clk) begin
        rnd = $random(seed);
        third_loop_pll_tick <= rnd[0];
        second_loop_pll_tick <= rnd[1];
        thr_cnt += rnd[0];
        sec_cnt += rnd[1];
    end
    always @(negedge link.cs_n) cs_stamp = vco ? sec_cnt : thr_cnt;
    // pin captures only run with the third loop selected; only the active edge is stamped
    always @(link.trig) begin
        if (link.trig[0] === stamp_lvl) begin
            pin_stamp = thr_cnt;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // tol lets a capture difference sit one count either side of the model
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input logic [39:0] tol);
        samples_checked++;
        if ((^got) === 1'bx || got > exp + tol || got + tol < exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask

    task automatic xfer(input logic rnw, input logic [6:0] da, input logic [2:0] len, input logic [7:0] tx);
        logic [7:0] b;
        int n;
        sw_wr(etcc_pkg::HREG_CMD, {rnw, da});
        sw_wr(etcc_pkg::HREG_LEN, {5'h00, len});
        sw_wr(etcc_pkg::HREG_BUF0, tx);
        sw_wr(etcc_pkg::HREG_CTRL, 8'h01);
        b = 8'h01;
        n = 0;
        while (b[0] !== 1'b0) begin
            sw_rd(etcc_pkg::HREG_CTRL, b);
            n++;
            if (n > 1000) begin
                err_total++;
                conclude();
            end
        end
        rx = 40'h0;
        for (int i = 0; i < (rnw ? int'(len) : 0); i++) begin
            sw_rd(etcc_pkg::HREG_BUF0 + 4'(i), b);
            rx[8*i +: 8] = b;
        end
    endtask

    task automatic cap_read();
        xfer(1'b1, etcc_pkg::REG_CAP0, 3'h5, 8'h00);
    endtask

    task automatic rearm();
        xfer(1'b1, etcc_pkg::REG_CAP0, 3'h1, 8'h00);
    endtask

    // the host holds trig back through its post-frame guard; 100 cycles always cover it
    task automatic set_trig(input logic [1:0] v);
        sw_wr(etcc_pkg::HREG_TRIG, {6'h00, v});
        repeat (100) @(posedge ref_clk);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        sw_rd(4'hf, b8);
        chk({32'h0000_0000, b8}, 40'h0, 40'h0);
        xfer(1'b1, etcc_pkg::REG_CTRL, 3'h1, 8'h00);
        chk(rx, 40'(etcc_pkg::CTRL_RESET), 40'h0);
        xfer(1'b1, 7'h40, 3'h1, 8'h00);
        chk(rx, 40'h0, 40'h0);
        cap_read();
        chk(rx, 40'h0, 40'h0);
        // capture bytes are read-only
        xfer(1'b0, etcc_pkg::REG_CAP0, 3'h1, 8'ha5);
        cap_read();
        chk(rx, 40'h0, 40'h0);
        for (int v = 0; v < 2; v++) begin
            vco = v[0];
            xfer(1'b0, etcc_pkg::REG_CTRL, 3'h1, {5'h00, vco, 2'h1});
            chk(40'(validation_vco_select), 40'(vco), 40'h0);
            rearm();
            cap_read();
            c1 = rx;
            s1 = cs_stamp;
            cap_read();
            chk(rx, c1, 40'h0);
            rearm();
            cap_read();
            chk(rx - c1, 40'((cs_stamp - s1) / (vco ? 20 : 8)), 40'h1);
        end
        // a burst from below the capture bytes rearms without relocking
        xfer(1'b1, 7'h0f, 3'h2, 8'h00);
        xfer(1'b1, 7'h0f, 3'h5, 8'h00);
        c1 = rx;
        s1 = cs_stamp;
        xfer(1'b1, 7'h0f, 3'h5, 8'h00);
        chk(40'(rx[39:8] - c1[39:8]), 40'((cs_stamp - s1) / 20), 40'h1);
        vco = 1'b0;
        // clear first so zero is captured; a disabled counter then captures nothing, so zero stays
        for (int k = 0; k < 2; k++) begin
            xfer(1'b0, etcc_pkg::REG_CTRL, 3'h1, k ? 8'h00 : 8'h09);
            rearm();
            cap_read();
            chk(rx, 40'h0, 40'h0);
        end
        // pin source; the other pin carries a non-capture code and must be ignored
        xfer(1'b0, etcc_pkg::REG_CTRL, 3'h1, 8'h03);
        for (int p = 0; p < 2; p++) begin
            stamp_lvl = ~p[0];
            xfer(1'b0, etcc_pkg::REG_PIN0 + 7'(p), 3'h1, {p[0], etcc_pkg::PIN_FUNC_CAPTURE});
            xfer(1'b0, etcc_pkg::REG_PIN0 + 7'(1 - p), 3'h1, 8'h26);
            set_trig({2{p[0]}});
            rearm();
            set_trig({2{~p[0]}});
            s1 = pin_stamp;
            set_trig({2{p[0]}});
            set_trig({2{~p[0]}});
            cap_read();
            c1 = rx;
            rearm();
            set_trig({2{p[0]}});
            set_trig({2{~p[0]}});
            cap_read();
            chk(rx - c1, 40'((pin_stamp - s1) / 8), 40'h1);
        end
        conclude();
    end
endmodule // elapsed_time_capture_counter_bench
